//--- rtl/spmp_defines.vh
// constants for the serial port modem pin block
`ifndef SPMP_DEFINES_VH
`define SPMP_DEFINES_VH
`define SPMP_TEST_MODE_BIT   7
`define SPMP_CFG_INDEX_LOW   8'h2e
`define SPMP_CFG_DATA_LOW    8'h2f
`define SPMP_CFG_INDEX_HIGH  8'h4e
`define SPMP_CFG_DATA_HIGH   8'h4f
`define SPMP_SYNC_STAGES     3
`endif

//--- rtl/spmp_sync.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module spmp_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
  input  wire             i_sys_clk,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // first stage feeds only the second; change counts when s2 and s3 agree
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      s1_q   <= INIT;
      s2_q   <= INIT;
      s3_q   <= INIT;
      o_sync <= INIT;
    end else begin
      s1_q   <= i_async;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      o_sync <= (s2_q & s3_q) | (o_sync & (s2_q | s3_q));
    end
  end
endmodule

//--- rtl/spmp_top.v
// pin-level modem control and status logic for two serial ports
// Behaviour
// - terminal-ready active low, high after reset
// - loopback holds terminal-ready inactive unless the test-mode bit is set
// - test-mode bit selects baud clock output
// - request-to-send active low, high after reset
// - loopback holds request-to-send inactive high
// - serial output idles high after reset
// - ring inputs monitored while power off
// - port one terminal-ready pin released in reset; strap taken from pull-down, always low
// - strap low 2e/2f, strap high 4e/4f
`timescale 1ns/100ps
`include "spmp_defines.vh"
module spmp_top (
  input  wire       i_sys_clk,
  input  wire       i_rst,
  input  wire [1:0] i_cts_n,
  input  wire [1:0] i_dcd_n,
  input  wire [1:0] i_dsr_n,
  input  wire [1:0] i_ri_n,
  input  wire [1:0] i_sin,
  input  wire [1:0] i_ctl_dtr,
  input  wire [1:0] i_ctl_rts,
  input  wire [1:0] i_loopback,
  input  wire [7:0] i_extended_control_reg_1,
  input  wire [7:0] i_extended_control_reg_2,
  input  wire [1:0] i_baud_clk,
  input  wire [1:0] i_tx_data,
  input  wire [1:0] i_tx_active,
  input  wire       i_main_power_on,
  output reg  [1:0] o_cts,
  output reg  [1:0] o_dcd,
  output reg  [1:0] o_dsr,
  output reg  [1:0] o_ri,
  output reg  [1:0] o_sin,
  output reg  [1:0] o_ring_wake,
  output reg        o_term_ready_baud_out_1,
  output reg        o_term_ready_baud_out_1_oe,
  output reg        o_term_ready_baud_out_2,
  output reg  [1:0] o_rts_n,
  output reg  [1:0] o_sout,
  output reg        o_base_select_strap,
  output reg  [7:0] o_cfg_index_addr,
  output reg  [7:0] o_cfg_data_addr
);
  // synchronised line pins, all ten in one bank
  wire [9:0] pins_s;
  // synchronised pins split out per signal, bit 0 is port one
  wire [1:0] cts_n_s;
  wire [1:0] dcd_n_s;
  wire [1:0] dsr_n_s;
  wire [1:0] sin_s;
  wire [1:0] ri_n_s;
  // strap pin level; only the on-chip pull-down acts on it here
  wire       strap_pin_w;
  wire       strap_s;
  // reset delayed one edge to find its trailing edge
  reg        rst_d1_q;
  // previous synchronised ring level for falling-edge detection
  reg  [1:0] ri_prev_q;
  // per-port baud-clock test mode
  wire [1:0] test_mode;
  // next terminal-ready pin levels
  wire [1:0] dtr_pin;
  // next request-to-send and serial-out pin levels
  wire [1:0] rts_pin;
  wire [1:0] sout_pin;
  // ring monitoring permission; main power state never gates it
  wire       ring_watch_en;

  // strap has no driver of its own here, the pull-down wins
  assign strap_pin_w = 1'b0;

  // synchronise all asynchronous line inputs
  spmp_sync #(.WIDTH(10), .INIT(10'h3ff)) u_sync_lines (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   ({i_ri_n, i_sin, i_dsr_n, i_dcd_n, i_cts_n}),
    .o_sync    (pins_s)
  );

  // strap path keeps running through reset so the level is settled at release
  spmp_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_strap (
    .i_sys_clk (i_sys_clk),
    .i_rst     (1'b0),
    .i_async   (strap_pin_w),
    .o_sync    (strap_s)
  );

  // split the synchronised bank back into named pins
  assign cts_n_s = pins_s[1:0];
  assign dcd_n_s = pins_s[3:2];
  assign dsr_n_s = pins_s[5:4];
  assign sin_s   = pins_s[7:6];
  assign ri_n_s  = pins_s[9:8];

  // test-mode bit of each port's extended control value
  assign test_mode = {i_extended_control_reg_2[`SPMP_TEST_MODE_BIT],
                      i_extended_control_reg_1[`SPMP_TEST_MODE_BIT]};

  // ring watch stays on in every power state
  assign ring_watch_en = ~i_main_power_on | 1'b1;

  // per-port terminal-ready pin value, test mode wins over loopback
  function pin_dtr;
    input ctl;
    input lb;
    input tm;
    input baud;
    begin
      if (tm)
        pin_dtr = baud;
      else if (lb)
        pin_dtr = 1'b1;
      else
        pin_dtr = ~ctl;
    end
  endfunction

  // per-port request-to-send pin value
  function pin_rts;
    input ctl;
    input lb;
    begin
      if (lb)
        pin_rts = 1'b1;
      else
        pin_rts = ~ctl;
    end
  endfunction

  // per-port serial-out pin value, idle high when not sending
  function pin_sout;
    input active;
    input data;
    input lb;
    begin
      if (active && !lb)
        pin_sout = data;
      else
        pin_sout = 1'b1;
    end
  endfunction

  // active-low pin pair to active-high status
  function [1:0] pin_asserted;
    input [1:0] lvl;
    begin
      pin_asserted = ~lvl;
    end
  endfunction

  // next pin levels for both ports
  assign dtr_pin[0]  = pin_dtr(i_ctl_dtr[0], i_loopback[0], test_mode[0], i_baud_clk[0]);
  assign dtr_pin[1]  = pin_dtr(i_ctl_dtr[1], i_loopback[1], test_mode[1], i_baud_clk[1]);
  assign rts_pin[0]  = pin_rts(i_ctl_rts[0], i_loopback[0]);
  assign rts_pin[1]  = pin_rts(i_ctl_rts[1], i_loopback[1]);
  assign sout_pin[0] = pin_sout(i_tx_active[0], i_tx_data[0], i_loopback[0]);
  assign sout_pin[1] = pin_sout(i_tx_active[1], i_tx_data[1], i_loopback[1]);

  // reset history for the strap capture
  always @(posedge i_sys_clk) begin
    rst_d1_q <= i_rst;
  end

  // terminal-ready pins; port one pin is a strap input during reset
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_term_ready_baud_out_1    <= 1'b1;
      o_term_ready_baud_out_1_oe <= 1'b0;
      o_term_ready_baud_out_2    <= 1'b1;
    end else begin
      o_term_ready_baud_out_1_oe <= 1'b1;
      o_term_ready_baud_out_1    <= dtr_pin[0];
      o_term_ready_baud_out_2    <= dtr_pin[1];
    end
  end

  // request-to-send and serial-out pins
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rts_n <= 2'h3;
      o_sout  <= 2'h3;
    end else begin
      o_rts_n <= rts_pin;
      o_sout  <= sout_pin;
    end
  end

  // decoded modem status, high means asserted; o_sin keeps the pin level
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cts <= 2'h0;
      o_dcd <= 2'h0;
      o_dsr <= 2'h0;
      o_ri  <= 2'h0;
      o_sin <= 2'h3;
    end else begin
      o_cts <= pin_asserted(cts_n_s);
      o_dcd <= pin_asserted(dcd_n_s);
      o_dsr <= pin_asserted(dsr_n_s);
      o_ri  <= pin_asserted(ri_n_s);
      o_sin <= sin_s;
    end
  end

  // ring wake pulse on each falling ring edge
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      ri_prev_q   <= 2'h3;  // idle pin level, no false edge after reset
      o_ring_wake <= 2'h0;
    end else begin
      ri_prev_q   <= ri_n_s;
      o_ring_wake <= ri_prev_q & ~ri_n_s & {2{ring_watch_en}};
    end
  end

  // strap taken on the trailing edge of reset
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_base_select_strap <= 1'b0;
      o_cfg_index_addr    <= `SPMP_CFG_INDEX_LOW;
      o_cfg_data_addr     <= `SPMP_CFG_DATA_LOW;
    end else if (rst_d1_q) begin
      o_base_select_strap <= strap_s;
      o_cfg_index_addr    <= strap_s ? `SPMP_CFG_INDEX_HIGH : `SPMP_CFG_INDEX_LOW;
      o_cfg_data_addr     <= strap_s ? `SPMP_CFG_DATA_HIGH : `SPMP_CFG_DATA_LOW;
    end
  end
endmodule

//--- testbench/spmp_modem.sv
// line-side modem model driving active-low status pins
`timescale 1ns/100ps
module spmp_modem (
  input  wire logic [7:0] i_req,
  output logic      [7:0] o_pin
);
  // asserted status goes out as a low level
  assign o_pin = ~i_req;
endmodule

//--- testbench/spmp_top_assertions.sv
// checker for the modem pin block ports
`timescale 1ns/100ps
module spmp_top_assertions (
  input wire logic i_sys_clk, i_rst, o_term_ready_baud_out_1_oe, o_term_ready_baud_out_2,
  input wire logic [1:0] i_cts_n, i_ri_n, i_ctl_dtr, i_ctl_rts, i_loopback, i_baud_clk, o_cts, o_ri, o_rts_n, o_sout,
  input wire logic [7:0] i_extended_control_reg_2, o_cfg_index_addr, o_cfg_data_addr
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  property p_rts; 1 |=> o_rts_n[0] == !($past(i_ctl_rts[0]) && !$past(i_loopback[0])); endproperty
  property p_dtr; 1 |=> o_term_ready_baud_out_2 == ($past(i_extended_control_reg_2[7]) ?
    $past(i_baud_clk[1]) : !($past(i_ctl_dtr[1]) && !$past(i_loopback[1]))); endproperty
  property p_sout; i_loopback[1] |=> o_sout[1]; endproperty
  property p_rst; disable iff (1'b0) i_rst |=> o_rts_n == 2'h3 && o_sout == 2'h3 &&
    !o_term_ready_baud_out_1_oe && o_term_ready_baud_out_2; endproperty
  property p_oe; 1 |=> o_term_ready_baud_out_1_oe; endproperty
  property p_cfg; o_cfg_index_addr == 8'h2e && o_cfg_data_addr == 8'h2f; endproperty
  property p_cts; !i_cts_n[0] [*6] |-> o_cts[0]; endproperty
  property p_ri; i_ri_n[1] [*6] |-> !o_ri[1]; endproperty
  a_rts: assert property (p_rts) else $error("rts mismatch");
  a_dtr: assert property (p_dtr) else $error("dtr mismatch");
  a_sout: assert property (p_sout) else $error("sout not idle");
  a_rst: assert property (p_rst) else $error("reset levels wrong");
  a_oe: assert property (p_oe) else $error("strap pin not driven");
  a_cfg: assert property (p_cfg) else $error("config pair wrong");
  a_cts: assert property (p_cts) else $error("cts not seen");
  a_ri: assert property (p_ri) else $error("ring seen wrongly");
  // main scenarios reached
  cover property (i_loopback[0] && i_ctl_rts[0]);
  cover property (i_extended_control_reg_2[7]);
  cover property (o_ri[0]);
endmodule
bind spmp_top spmp_top_assertions u_chk (.*);

//--- testbench/tb_spmp_top.sv
// self-checking bench for the modem pin block
`timescale 1ns/100ps
module tb_spmp_top;
  logic clk = 0, rst = 1, pwr = 1;
  logic [1:0] rts = 0, dtr = 0, lb = 0, baud = 0, txa = 0, txd = 0;
  wire  [1:0] rw, osin;
  wire        strap;
  logic [7:0] req = 0, e2 = 0;
  wire  [7:0] pin, st;
  wire  [1:0] orts, osout;
  wire        t1, t1oe, t2;
  wire  [7:0] ia, da;
  int errors = 0, tests_run = 0;
  spmp_modem u_mdm (.i_req(req), .o_pin(pin));
  spmp_top DUT (.i_sys_clk(clk), .i_rst(rst), .i_cts_n(pin[7:6]), .i_dcd_n(pin[5:4]), .i_dsr_n(pin[3:2]),
    .i_ri_n(pin[1:0]), .i_sin(2'h3), .i_ctl_dtr(dtr), .i_ctl_rts(rts), .i_loopback(lb),
    .i_extended_control_reg_1(8'h00), .i_extended_control_reg_2(e2), .i_baud_clk(baud), .i_tx_data(txd),
    .i_tx_active(txa), .i_main_power_on(pwr), .o_cts(st[7:6]), .o_dcd(st[5:4]), .o_dsr(st[3:2]),
    .o_ri(st[1:0]), .o_sin(osin), .o_ring_wake(rw), .o_term_ready_baud_out_1(t1), .o_term_ready_baud_out_1_oe(t1oe),
    .o_term_ready_baud_out_2(t2), .o_rts_n(orts), .o_sout(osout), .o_base_select_strap(strap), .o_cfg_index_addr(ia),
    .o_cfg_data_addr(da));
  initial forever #2.5 clk = ~clk;
  task cyc(int n); repeat (n) @(posedge clk); #1; endtask
  task chk(logic [7:0] g, logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("unexpected %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // loopback on both ready pins, then test mode on the port two ready pin
  task t_ctl;
    @(posedge clk); rts <= 3; dtr <= 3; cyc(2);
    chk({orts, t2, t1}, 8'h0);
    chk({orts, osout, t2, t1, t1oe}, 8'h19);
    @(posedge clk); txa <= 3; txd <= 2; cyc(2); chk(osout, 8'h2);
    @(posedge clk); lb <= 3; cyc(2);
    chk({orts, osout, t2, t1}, 8'h3f);
    @(posedge clk); e2 <= 8'h80; cyc(2); chk(t2, 0);
    @(posedge clk); baud <= 2; cyc(2); chk(t2, 1);
    $display("ctl done");
  endtask
  // status pins with main power off
  task t_stat;
    @(posedge clk); pwr <= 0; req <= 8'hff; cyc(5); chk(rw, 8'h3);
    cyc(1); chk(rw, 8'h0);
    chk(st, 8'hff);
    @(posedge clk); req <= 8'h41; cyc(6); chk(st, 8'h41);
    $display("stat done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    cyc(1); chk({ia, da}, 8'h2f);
    chk(ia, 8'h2e);
    chk({osin, strap}, 8'h6);
    t_ctl;
    t_stat;
    finish_test;
  end
  initial begin
    #20000;
    errors++;
    finish_test;
  end
endmodule
